/* File: bench/nand_dev_model.sv */
// behavioural flash device facing the host sequencer pins
// assumes registered host pins; busy length set by the bench, fixed at 40 cycles after FFh
`timescale 1ns/1ps
module nand_dev_model (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire nand_host_pkg::pins_s pins,
	input  wire logic [15:0]          busy_cyc,
	output logic [7:0]                io_wire,
	output logic                      ready_busy_n
);
	logic [7:0]  log_q[$];
	logic [15:0] cnt_r;
	logic [7:0]  idx_r;
	logic [7:0]  last_r;
	logic        stat_r;
	logic        drive;
	wire         code_wr = !pins.ce_n && pins.cle && !pins.we_n;
	////////////////////////////////////////
	// pin low while busy
	assign ready_busy_n = (cnt_r == 16'h0000);
	assign drive   = !pins.ce_n && !pins.read_strobe_n;
	assign io_wire = pins.io_oe ? pins.io_out : drive ? (stat_r ? {1'b0, ready_busy_n, 6'h00} : 8'hA5 ^ idx_r) : ~last_r;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r  <= 16'h0000;
			idx_r  <= 8'h00;
			stat_r <= 1'b0;
			last_r <= 8'h00;
		end else begin
			last_r <= io_wire;
			if (cnt_r != 16'h0000) cnt_r <= cnt_r - 16'h0001;
			if (!pins.read_strobe_n) idx_r <= idx_r + 8'h01;
			if (code_wr) begin
				log_q.push_back(pins.io_out);
				stat_r <= (pins.io_out == 8'h70);
				idx_r  <= 8'h00;
				if (pins.io_out == 8'hFF) cnt_r <= 16'h0028;
				else if (pins.io_out inside {8'h10, 8'h11, 8'h15, 8'h30, 8'h31, 8'h3F, 8'h3A}) cnt_r <= busy_cyc;
			end
		end
	end
endmodule

/* File: bench/nand_host_checker.sv */
// port assertions for the flash host sequencer
// assumes binding onto nand_host with one clock, mclk
`timescale 1ns/1ps
module nand_host_checker (
	input wire logic                   mclk,
	input wire logic                   rst,
	input wire logic                   done,
	input wire nand_host_pkg::result_s result,
	input wire nand_host_pkg::pins_s   pins,
	input wire logic                   ready_busy_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] last_code_r;
	logic       pend_r;
	wire        code_wr = !pins.ce_n && pins.cle && !pins.we_n;
	////////////////////////////////////////
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_code_r <= 8'hFF;
			pend_r      <= 1'b0;
		end else if (code_wr) begin
			last_code_r <= pins.io_out;
			pend_r      <= (pins.io_out == 8'h15) || (pend_r && pins.io_out == 8'h70);
		end
	end
	////////////////////////////////////////
	chk_no_bus_fight: assert property (!pins.read_strobe_n |-> !pins.io_oe && pins.we_n)
		else $error("host drives io during a read");
	chk_read_quiet: assert property (!pins.read_strobe_n |-> !pins.ce_n && !pins.cle && !pins.ale)
		else $error("latch lines move during a read");
	chk_strobe_pulse: assert property ($fell(pins.read_strobe_n) |=> $rose(pins.read_strobe_n))
		else $error("read strobe low too long");
	chk_wait_ready: assert property (code_wr && !(pins.io_out inside {8'h70, 8'hFF}) |-> ready_busy_n)
		else $error("command issued while busy");
	chk_confirm_order: assert property (code_wr && pins.io_out inside {8'h10, 8'h11, 8'h15}
		|-> last_code_r == 8'h80) else $error("confirm without data input");
	chk_recovery_seq: assert property (code_wr && pend_r |-> pins.io_out inside {8'h70, 8'hFF, 8'h80})
		else $error("no status poll and reset after cache end");
	chk_refused_quiet: assert property (done && result.refused
		|-> $past(pins.we_n, 1) && $past(pins.we_n, 2)) else $error("refused program reached the pins");
	chk_latch_select: assert property ($fell(pins.we_n) |-> !pins.ce_n && !(pins.cle && pins.ale))
		else $error("write strobe without select");
	cov_refused: cover property (done && result.refused);
	cov_timeout: cover property (done && result.timeout);
	cov_recovery: cover property (code_wr && pend_r && pins.io_out == 8'hFF);
	cov_read: cover property ($fell(pins.read_strobe_n));
endmodule

bind nand_host nand_host_checker chk (.mclk(mclk), .rst(rst), .done(done), .result(result), .pins(pins),
	.ready_busy_n(ready_busy_n));

/* File: bench/tb_top.sv */
// self-checking bench for the flash host sequencer
// assumes nand_dev_model as the flash and the bound checker
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
	$display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
	logic                   mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0, took = 1'b0;
	logic                   cmd_ready, wr_ready, rd_valid, done, ready_busy_n;
	logic [7:0]             wr_data = 8'h00, rd_data, io_in, rd_q[$];
	logic [15:0]            busy_cyc = 16'h0014;
	logic [23:0]            page;
	nand_host_pkg::cmd_s    cmd_in = '0;
	nand_host_pkg::result_s result;
	nand_host_pkg::pins_s   pins;
	int                     mismatches = 0, n_tests = 0, n;
	nand_host_pkg::op_e     rd_ops[4] = '{nand_host_pkg::OP_READ, nand_host_pkg::OP_READ_CACHE,
		nand_host_pkg::OP_READ_LAST, nand_host_pkg::OP_PAGE_COPY};
	logic [7:0]             exp_log[4] = '{8'h80, 8'h11, 8'h80, 8'h10};
	always #25 mclk = ~mclk;
	nand_host #(.T_RST_ERASE_CYC(300), .T_PROG_CYC(600), .T_CACHE_CYC(600)) DUT (.mclk, .rst, .cmd_valid,
		.cmd_ready, .cmd_in, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .done, .result, .pins,
		.io_in, .ready_busy_n);
	nand_dev_model dev (.mclk, .rst, .pins, .busy_cyc, .io_wire(io_in), .ready_busy_n);
	////////////////////////////////////////
	function automatic logic [7:0] exp_byte(input int i);
		return 8'hA5 ^ 8'(i);
	endfunction
	function automatic logic exp_late(input logic [15:0] b, input int lim);
		return b > lim;
	endfunction
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic run_cmd(input logic rs, input nand_host_pkg::op_e op, input logic [39:0] a,
		input logic [11:0] len, input string nm);
		int k;
		rd_q.delete();
		cmd_in = '{rs, op, a, len};
		cmd_valid = 1'b1;
		#1;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 4000) begin
			@(negedge mclk);
			k++;
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && k < 20000) begin
			@(negedge mclk);
			k++;
		end
		#1;
		if (k >= 20000) mismatches++;
		$display("test %s ended after %0d cycles", nm, k);
	endtask
	////////////////////////////////////////
	always @(negedge mclk) begin
		if (took || !wr_valid) begin
			wr_valid = 1'($urandom_range(1, 0));
			wr_data = 8'($urandom);
		end
		took = wr_valid && wr_ready;
	end
	always @(negedge mclk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
	initial begin
		#(80000 * 50);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		void'($urandom(32'h6BAF));
		for (int i = 0; i < 4; i++) begin
			busy_cyc = 16'($urandom_range(300, 20));
			n = $urandom_range(8, 1);
			run_cmd(1'b0, rd_ops[i], 40'($urandom), 12'(n), "read");
			`CHK("read_timeout", result.timeout, exp_late(busy_cyc, (i == 3) ? 600 : 500))
			`CHK("read_count", rd_q.size(), n)
			for (int j = 0; j < rd_q.size(); j++) `CHK("read_byte", rd_q[j], exp_byte(j))
		end
		busy_cyc = 16'h0384;
		run_cmd(1'b0, nand_host_pkg::OP_READ, 40'h0, 12'h001, "slow_read");
		`CHK("slow_timeout", result.timeout, exp_late(busy_cyc, 500))
		run_cmd(1'b1, nand_host_pkg::OP_READ, 40'h0, 12'h000, "reset");
		`CHK("reset_timeout", result.timeout, 1'b0)
		`CHK("reset_ready", ready_busy_n, 1'b1)
		page = 24'($urandom);
		for (int i = 0; i < 6; i++) begin
			busy_cyc = 16'($urandom_range(300, 20));
			run_cmd(1'b0, nand_host_pkg::OP_PROG, {page + 24'(i / 5), 16'($urandom)}, 12'($urandom_range(4, 1)), "prog");
			`CHK("prog_refused", result.refused, 1'(i == 4))
		end
		dev.log_q.delete();
		busy_cyc = 16'($urandom_range(150, 20));
		run_cmd(1'b0, nand_host_pkg::OP_CACHE_SHORT, {page ^ 24'h00F00F, 16'h0}, 12'h002, "cache_short");
		`CHK("short_timeout", result.timeout, 1'b0)
		run_cmd(1'b0, nand_host_pkg::OP_PROG, {page ^ 24'h0F00F0, 16'h0}, 12'h002, "cache_end");
		`CHK("end_timeout", result.timeout, 1'b0)
		for (int i = 0; i < 4; i++) `CHK("cache_codes", dev.log_q[i], exp_log[i])
		busy_cyc = 16'($urandom_range(500, 200));
		run_cmd(1'b0, nand_host_pkg::OP_CACHE_LONG, {page ^ 24'hFFFFFF, 16'h0}, 12'h003, "cache_long");
		`CHK("long_timeout", result.timeout, exp_late(busy_cyc, 600))
		dev.log_q.delete();
		busy_cyc = 16'h0020;
		run_cmd(1'b0, nand_host_pkg::OP_READ, 40'h0, 12'h001, "recover_read");
		`CHK("recover_poll", dev.log_q[0], 8'h70)
		`CHK("recover_reset", dev.log_q[dev.log_q.size() - 3], 8'hFF)
		run_cmd(1'b0, nand_host_pkg::OP_STATUS, 40'h0, 12'h000, "status");
		`CHK("status", result.status, 8'h40)
		wrap_up();
	end
endmodule

/* File: verilog/nand_host.sv */
// host sequencer driving an asynchronous nand flash through its strobes
// assumes a pulled-up ready/busy line and the io wire resolved outside
//
// What this block does
// - a page is programmed no more than four times in a row; a program to another page restarts the count
// - cached programming is ended by 80h then confirm 10h
// - after a 15h ending poll status bit 6 then issue FFh
// - host never drives io while the device drives read data
// - cache program is 80h ... 15h (long) or 80h ... 11h (short), plain program is 80h ... 10h
`timescale 1ns/1ps
`include "nand_host_regs.svh"

module nand_host #(
	parameter int T_RST_ERASE_CYC = `NF_CYC_US(`NF_T_RST_ERASE_US),
	parameter int T_PROG_CYC      = `NF_CYC_US(`NF_T_PROG_US),
	parameter int T_CACHE_CYC     = `NF_CYC_US(`NF_T_CACHE_LONG_US)
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire nand_host_pkg::cmd_s   cmd_in,
	input  wire logic                  wr_valid,
	output logic                       wr_ready,
	input  wire logic [7:0]            wr_data,
	output logic                       rd_valid,
	output logic [7:0]                 rd_data,
	output logic                       done,
	output nand_host_pkg::result_s     result,
	output nand_host_pkg::pins_s       pins,
	input  wire logic [7:0]            io_in,
	input  wire logic                  ready_busy_n
);

	localparam logic [15:0] L_WB    = 16'(`NF_CYC_NS(`NF_T_WB_NS));
	localparam logic [15:0] L_WHR   = 16'(`NF_CYC_NS(`NF_T_WHR_NS));
	// busy edge must pass the three-stage synchroniser before busy is judged
	localparam logic [15:0] L_WBS   = L_WB + 16'h0003;
	localparam logic [15:0] L_RST_Y = 16'(`NF_CYC_US(`NF_T_RST_READY_US));
	localparam logic [15:0] L_RST_R = 16'(`NF_CYC_US(`NF_T_RST_READ_US));
	localparam logic [15:0] L_RST_P = 16'(`NF_CYC_US(`NF_T_RST_PROG_US));
	localparam logic [15:0] L_RST_E = 16'(T_RST_ERASE_CYC);
	localparam logic [15:0] L_PROG  = 16'(T_PROG_CYC);
	localparam logic [15:0] L_CL    = 16'(T_CACHE_CYC);
	localparam logic [15:0] L_CS    = 16'(`NF_CYC_US(`NF_T_CACHE_SHORT_US));
	localparam logic [15:0] L_AR    = 16'(`NF_CYC_US(`NF_T_ARRAY_READ_US));
	localparam logic [15:0] L_RC    = 16'(`NF_CYC_US(`NF_T_READ_CACHE_US));
	localparam logic [15:0] L_PC    = 16'(`NF_CYC_US(`NF_T_PAGE_COPY_US));

	////////////////////////////////////////////////////////////////
	// command decoding

	function automatic logic [7:0] code1(input nand_host_pkg::cmd_s c);
		if (c.is_reset)
			return `NF_C_RESET;
		case (c.op)
			nand_host_pkg::OP_READ_CACHE: return `NF_C_READ_CACHE;
			nand_host_pkg::OP_READ_LAST:  return `NF_C_READ_CACHE_END;
			nand_host_pkg::OP_STATUS:     return `NF_C_STATUS;
			nand_host_pkg::OP_PROG,
			nand_host_pkg::OP_CACHE_LONG,
			nand_host_pkg::OP_CACHE_SHORT: return `NF_C_DATA_IN;
			default:                      return `NF_C_READ;
		endcase
	endfunction

	function automatic logic [7:0] code2(input nand_host_pkg::op_e o);
		case (o)
			nand_host_pkg::OP_PROG:        return `NF_C_PROG_GO;
			nand_host_pkg::OP_CACHE_LONG:  return `NF_C_CACHE_LONG;
			nand_host_pkg::OP_CACHE_SHORT: return `NF_C_CACHE_SHORT;
			nand_host_pkg::OP_PAGE_COPY:   return `NF_C_PAGE_COPY;
			default:                       return `NF_C_READ_GO;
		endcase
	endfunction

	function automatic logic is_prog(input nand_host_pkg::op_e o);
		return o == nand_host_pkg::OP_PROG || o == nand_host_pkg::OP_CACHE_LONG ||
			o == nand_host_pkg::OP_CACHE_SHORT;
	endfunction

	function automatic logic has_addr(input nand_host_pkg::cmd_s c);
		return !c.is_reset && (is_prog(c.op) || c.op == nand_host_pkg::OP_READ ||
			c.op == nand_host_pkg::OP_PAGE_COPY);
	endfunction

	function automatic logic has_rd(input nand_host_pkg::cmd_s c);
		return !c.is_reset && !is_prog(c.op);
	endfunction

	function automatic logic [15:0] busy_lim(input nand_host_pkg::cmd_s c, input nand_host_pkg::dev_e d);
		if (c.is_reset) begin
			case (d)
				nand_host_pkg::DEV_READ:  return L_RST_R;
				nand_host_pkg::DEV_PROG:  return L_RST_P;
				nand_host_pkg::DEV_ERASE: return L_RST_E;
				default:                  return L_RST_Y;
			endcase
		end
		case (c.op)
			nand_host_pkg::OP_PROG:        return L_PROG;
			nand_host_pkg::OP_CACHE_LONG:  return L_CL;
			nand_host_pkg::OP_CACHE_SHORT: return L_CS;
			nand_host_pkg::OP_READ_CACHE,
			nand_host_pkg::OP_READ_LAST:   return L_RC;
			nand_host_pkg::OP_PAGE_COPY:   return L_PC;
			default:                       return L_AR;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// state

	nand_host_pkg::state_e  st_r, st_nxt;
	nand_host_pkg::cmd_s    cmd_r, cmd_nxt;
	nand_host_pkg::result_s res_r, res_nxt;
	nand_host_pkg::pins_s   pin_r, pin_nxt;
	nand_host_pkg::dev_e    dev_r, dev_nxt;
	logic                   ph_r, ph_nxt;
	logic [11:0]            cnt_r, cnt_nxt;
	logic [2:0]             ab_r, ab_nxt;
	logic [15:0]            tmr_r, tmr_nxt;
	logic [7:0]             rdd_r, rdd_nxt;
	logic                   rdv_r, rdv_nxt;
	logic                   done_r, done_nxt;
	logic                   copen_r, copen_nxt;
	logic                   recov_r, recov_nxt;
	logic [23:0]            pg_r, pg_nxt;
	logic [2:0]             pcnt_r, pcnt_nxt;
	logic [2:0]             rbs_r, rbs_nxt;
	logic                   rdy_r, rdy_nxt;
	logic                   need_recov;

	assign rd_valid = rdv_r;
	assign rd_data  = rdd_r;
	assign done     = done_r;
	assign result   = res_r;
	assign pins     = pin_r;

	// open 15h ending must be closed first
	assign need_recov = copen_r && !(cmd_in.op == nand_host_pkg::OP_CACHE_LONG ||
		cmd_in.op == nand_host_pkg::OP_CACHE_SHORT || cmd_in.op == nand_host_pkg::OP_PROG || cmd_in.is_reset);

	////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		st_nxt     = st_r;
		cmd_nxt    = cmd_r;
		res_nxt    = res_r;
		dev_nxt    = dev_r;
		ph_nxt     = ph_r;
		cnt_nxt    = cnt_r;
		ab_nxt     = ab_r;
		tmr_nxt    = tmr_r;
		rdd_nxt    = rdd_r;
		rdv_nxt    = 1'b0;
		done_nxt   = 1'b0;
		copen_nxt  = copen_r;
		recov_nxt  = recov_r;
		pg_nxt     = pg_r;
		pcnt_nxt   = pcnt_r;
		cmd_ready  = 1'b0;
		wr_ready   = 1'b0;
		// ready level counts when two stages agree
		rbs_nxt    = {rbs_r[1:0], ready_busy_n};
		rdy_nxt    = (rbs_r[1] == rbs_r[2]) ? rbs_r[2] : rdy_r;
		pin_nxt    = pin_r;
		pin_nxt.ce_n          = 1'b0;
		pin_nxt.cle           = 1'b0;
		pin_nxt.ale           = 1'b0;
		pin_nxt.we_n          = 1'b1;
		pin_nxt.read_strobe_n = 1'b1;
		pin_nxt.wp_n          = 1'b1;
		// io driven only in write phases
		pin_nxt.io_oe         = 1'b0;
		case (st_r)
			nand_host_pkg::S_IDLE: begin
				pin_nxt.ce_n = 1'b1;
				ph_nxt  = 1'b0;
				ab_nxt  = 3'h0;
				tmr_nxt = 16'h0000;
				if (cmd_valid && need_recov) begin
					// poll status before the next operation
					recov_nxt   = 1'b1;
					cmd_nxt     = '0;
					cmd_nxt.op  = nand_host_pkg::OP_STATUS;
					cnt_nxt     = 12'h001;
					st_nxt      = nand_host_pkg::S_CMD1;
				end else if (cmd_valid) begin
					cmd_ready = 1'b1;
					cmd_nxt   = cmd_in;
					res_nxt   = '0;
					cnt_nxt   = (cmd_in.op == nand_host_pkg::OP_STATUS) ? 12'h001 : cmd_in.len;
					// wait ready except for status or reset
					st_nxt    = (cmd_in.is_reset || cmd_in.op == nand_host_pkg::OP_STATUS) ?
						nand_host_pkg::S_CMD1 : nand_host_pkg::S_WRDY;
					if (!cmd_in.is_reset && is_prog(cmd_in.op)) begin
						if (cmd_in.addr[39:16] == pg_r && pcnt_r == `NF_PARTIAL_MAX) begin
							res_nxt.refused = 1'b1;
							st_nxt = nand_host_pkg::S_DONE;
						end else begin
							pg_nxt   = cmd_in.addr[39:16];
							pcnt_nxt = (cmd_in.addr[39:16] == pg_r) ? pcnt_r + 3'h1 : 3'h1;
							copen_nxt = (cmd_in.op == nand_host_pkg::OP_CACHE_LONG);
							dev_nxt   = nand_host_pkg::DEV_PROG;
						end
					end else if (!cmd_in.is_reset && cmd_in.op != nand_host_pkg::OP_STATUS) begin
						dev_nxt = nand_host_pkg::DEV_READ;
					end
				end
			end
			nand_host_pkg::S_WRDY: begin
				if (rdy_r)
					st_nxt = nand_host_pkg::S_CMD1;
			end
			nand_host_pkg::S_CMD1: begin
				pin_nxt.cle    = 1'b1;
				pin_nxt.io_oe  = 1'b1;
				pin_nxt.io_out = code1(cmd_r);
				pin_nxt.we_n   = ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					if (has_addr(cmd_r))
						st_nxt = nand_host_pkg::S_ADDR;
					else if (!cmd_r.is_reset && cmd_r.op == nand_host_pkg::OP_STATUS)
						st_nxt = nand_host_pkg::S_GAP;
					else
						st_nxt = nand_host_pkg::S_WB;
				end
			end
			nand_host_pkg::S_ADDR: begin
				pin_nxt.ale    = 1'b1;
				pin_nxt.io_oe  = 1'b1;
				pin_nxt.io_out = cmd_r.addr[{ab_r, 3'b000} +: 8];
				pin_nxt.we_n   = ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					ab_nxt = ab_r + 3'h1;
					if (ab_r == 3'h4)
						st_nxt = (is_prog(cmd_r.op) && cnt_r != 12'h000) ? nand_host_pkg::S_DIN : nand_host_pkg::S_CMD2;
				end
			end
			nand_host_pkg::S_DIN: begin
				pin_nxt.io_oe = 1'b1;
				if (!ph_r) begin
					wr_ready = 1'b1;
					if (wr_valid) begin
						pin_nxt.io_out = wr_data;
						pin_nxt.we_n   = 1'b0;
						ph_nxt = 1'b1;
					end
				end else begin
					ph_nxt  = 1'b0;
					cnt_nxt = cnt_r - 12'h001;
					if (cnt_r == 12'h001)
						st_nxt = nand_host_pkg::S_CMD2;
				end
			end
			nand_host_pkg::S_CMD2: begin
				pin_nxt.cle    = 1'b1;
				pin_nxt.io_oe  = 1'b1;
				pin_nxt.io_out = code2(cmd_r.op);
				pin_nxt.we_n   = ph_r;
				ph_nxt = !ph_r;
				if (ph_r)
					st_nxt = nand_host_pkg::S_WB;
			end
			nand_host_pkg::S_WB: begin
				tmr_nxt = tmr_r + 16'h0001;
				if (tmr_r == L_WBS) begin
					tmr_nxt = 16'h0000;
					st_nxt  = nand_host_pkg::S_BUSY;
				end
			end
			nand_host_pkg::S_BUSY: begin
				tmr_nxt = tmr_r + 16'h0001;
				if (rdy_r) begin
					dev_nxt = nand_host_pkg::DEV_READY;
					tmr_nxt = 16'h0000;
					if (cmd_r.is_reset)
						copen_nxt = 1'b0;
					st_nxt  = (has_rd(cmd_r) && cnt_r != 12'h000) ? nand_host_pkg::S_GAP : nand_host_pkg::S_DONE;
				end else if (tmr_r == busy_lim(cmd_r, dev_r)) begin
					res_nxt.timeout = 1'b1;
					st_nxt = nand_host_pkg::S_DONE;
				end
			end
			nand_host_pkg::S_GAP: begin
				tmr_nxt = tmr_r + 16'h0001;
				ph_nxt  = 1'b0;
				if (tmr_r == L_WHR)
					st_nxt = nand_host_pkg::S_RD;
			end
			nand_host_pkg::S_RD: begin
				// strobe high a full cycle, capture while low
				pin_nxt.read_strobe_n = ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					cnt_nxt = cnt_r - 12'h001;
					if (cmd_r.op == nand_host_pkg::OP_STATUS) begin
						res_nxt.status = io_in;
					end else begin
						rdd_nxt = io_in;
						rdv_nxt = 1'b1;
					end
					if (cnt_r == 12'h001)
						st_nxt = nand_host_pkg::S_DONE;
				end
			end
			nand_host_pkg::S_DONE: begin
				// ce rise ends any extended output drive
				pin_nxt.ce_n = 1'b1;
				ph_nxt  = 1'b0;
				tmr_nxt = 16'h0000;
				st_nxt  = nand_host_pkg::S_IDLE;
				if (!recov_r) begin
					done_nxt = 1'b1;
				end else if (cmd_r.is_reset) begin
					recov_nxt = 1'b0;
				end else begin
					// bit 6 ready then reset, else poll again
					if (res_r.status[`NF_STAT_READY_BIT])
						cmd_nxt.is_reset = 1'b1;
					cnt_nxt = 12'h001;
					st_nxt  = nand_host_pkg::S_CMD1;
				end
			end
			default: st_nxt = nand_host_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r    <= nand_host_pkg::S_IDLE;
			cmd_r   <= '0;
			res_r   <= '0;
			dev_r   <= nand_host_pkg::DEV_READY;
			pin_r   <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
				wp_n: 1'b0, io_out: 8'h00, io_oe: 1'b0};
			ph_r    <= 1'b0;
			cnt_r   <= 12'h000;
			ab_r    <= 3'h0;
			tmr_r   <= 16'h0000;
			rdd_r   <= 8'h00;
			rdv_r   <= 1'b0;
			done_r  <= 1'b0;
			copen_r <= 1'b0;
			recov_r <= 1'b0;
			pg_r    <= 24'hFFFFFF;
			pcnt_r  <= 3'h0;
			rbs_r   <= 3'h0;
			rdy_r   <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cmd_r   <= cmd_nxt;
			res_r   <= res_nxt;
			dev_r   <= dev_nxt;
			pin_r   <= pin_nxt;
			ph_r    <= ph_nxt;
			cnt_r   <= cnt_nxt;
			ab_r    <= ab_nxt;
			tmr_r   <= tmr_nxt;
			rdd_r   <= rdd_nxt;
			rdv_r   <= rdv_nxt;
			done_r  <= done_nxt;
			copen_r <= copen_nxt;
			recov_r <= recov_nxt;
			pg_r    <= pg_nxt;
			pcnt_r  <= pcnt_nxt;
			rbs_r   <= rbs_nxt;
			rdy_r   <= rdy_nxt;
		end
	end

endmodule

/* File: verilog/nand_host_pkg.sv */
// types shared by the flash host sequencer and its users
// assumes nothing beyond a SystemVerilog compiler
package nand_host_pkg;

	typedef enum logic [2:0] {
		OP_READ        = 3'b000,
		OP_PROG        = 3'b001,
		OP_CACHE_LONG  = 3'b010,
		OP_CACHE_SHORT = 3'b011,
		OP_READ_CACHE  = 3'b100,
		OP_READ_LAST   = 3'b101,
		OP_PAGE_COPY   = 3'b110,
		OP_STATUS      = 3'b111
	} op_e;

	typedef enum logic [1:0] {
		DEV_READY = 2'b00,
		DEV_READ  = 2'b01,
		DEV_PROG  = 2'b10,
		DEV_ERASE = 2'b11
	} dev_e;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_WRDY = 4'h1,
		S_CMD1 = 4'h2,
		S_ADDR = 4'h3,
		S_DIN  = 4'h4,
		S_CMD2 = 4'h5,
		S_WB   = 4'h6,
		S_BUSY = 4'h7,
		S_GAP  = 4'h8,
		S_RD   = 4'h9,
		S_DONE = 4'hA
	} state_e;

	typedef struct packed {
		logic        is_reset;
		op_e         op;
		logic [39:0] addr;
		logic [11:0] len;
	} cmd_s;

	typedef struct packed {
		logic       timeout;
		logic       refused;
		logic [7:0] status;
	} result_s;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       read_strobe_n;
		logic       wp_n;
		logic [7:0] io_out;
		logic       io_oe;
	} pins_s;

endpackage

/* File: verilog/nand_host_regs.svh */
// timing counts and command codes of the flash host sequencer
// assumes a single system clock whose rate is given in MHz below
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

`define NF_CLK_MHZ          20
// longest times in us, exact whole cycles at this rate
`define NF_CYC_US(us)       ((us) * `NF_CLK_MHZ)
// least times in ns, rounded up to whole cycles
`define NF_CYC_NS(ns)       (((ns) * `NF_CLK_MHZ + 999) / 1000)

`define NF_T_RST_READY_US   5
`define NF_T_RST_READ_US    5
`define NF_T_RST_PROG_US    10
`define NF_T_RST_ERASE_US   500
`define NF_T_PROG_US        700
`define NF_T_CACHE_SHORT_US 10
`define NF_T_CACHE_LONG_US  700
`define NF_T_ARRAY_READ_US  25
`define NF_T_READ_CACHE_US  25
`define NF_T_PAGE_COPY_US   30
`define NF_T_WB_NS          100
`define NF_T_WHR_NS         60

`define NF_PARTIAL_MAX      3'h4
`define NF_STAT_READY_BIT   6

`define NF_C_READ           8'h00
`define NF_C_READ_GO        8'h30
`define NF_C_DATA_IN        8'h80
`define NF_C_PROG_GO        8'h10
`define NF_C_CACHE_SHORT    8'h11
`define NF_C_CACHE_LONG     8'h15
`define NF_C_READ_CACHE     8'h31
`define NF_C_READ_CACHE_END 8'h3F
`define NF_C_PAGE_COPY      8'h3A
`define NF_C_STATUS         8'h70
`define NF_C_RESET          8'hFF

`endif
